/* File: rtl/relative_branch_bit_ops.sv */
// Executor for relative branches, bit set and bit-test-skip instructions
//
// Summary of operation
// - The unconditional jump adds twice its signed 11-bit offset to the program counter.
// - The unconditional jump is opcode 1101 then 0, with an 11-bit offset -1024..1023.
// - The target is the current address plus 2 plus twice the offset.
// - The unconditional jump takes two cycles, the second an idle refill cycle.
// - The zero-clear jump redirects in two cycles when zero is 0, else falls through in one.
// - Skip-when-clear is opcode 1011, bit index, access bit and 8-bit register address.
// - A true skip discards the prefetched instruction and runs an idle cycle instead.
module relative_branch_bit_ops
    import branch_bit_pkg::*;
(
    input wire logic clock, // Core clock, four phases per instruction cycle
    input wire logic sys_rst, // Synchronous reset, active high
    input wire logic [15:0] instr_word, // Fetched instruction word
    input wire logic instr_valid, // Instruction word present for this cycle
    input wire logic zero_flag, // Status zero flag
    input wire logic [7:0] file_rd_data, // Data read from the addressed register
    output logic [20:0] program_counter, // Address of the instruction being executed
    output logic [7:0] file_addr, // Register address for read and write
    output logic file_access_sel, // Access bank select bit of the instruction
    output logic [7:0] file_wr_data, // Data written back
    output logic file_wr_en, // Write strobe, one pulse in phase 0 of the next cycle
    output logic idle_cycle, // Current instruction cycle executes as no operation
    output logic [1:0] phase, // Current phase, 0 to 3
    output logic instr_taken // Pulse in phase 0 of the cycle after each cycle that consumes the word
);
    ////////////////////////////////////////////////////////////////////////
    decode_if dec ();
    assign dec.instr = instr_word;

    instr_field_decoder u_decoder (
        .dec(dec)
    );

    ////////////////////////////////////////////////////////////////////////
    logic [1:0] phase_reg, phase_next;
    logic [20:0] pc_reg, pc_next;
    logic idle_reg, idle_next;
    logic [7:0] addr_reg, addr_next;
    logic acc_reg, acc_next;
    logic [7:0] wdata_reg, wdata_next;
    logic wen_reg, wen_next;
    logic taken_reg, taken_next;
    op_kind_t kind_reg, kind_next;
    logic [2:0] bit_reg, bit_next;
    logic [20:0] off_reg, off_next;
    logic hold_reg, hold_next;

    ////////////////////////////////////////////////////////////////////////
    // Target of a relative branch: the current counter plus the step plus the offset
    function automatic logic [20:0] branch_target(input logic [20:0] base,
        input logic [20:0] offset);
        return base + PC_STEP + offset;
    endfunction

    // True when a bit test must drop the prefetched word
    function automatic logic skip_hit(input op_kind_t kind, input logic [7:0] data,
        input logic [2:0] idx);
        logic bit_val;
        bit_val = data[idx];
        return (kind == OP_SKIP_CLEAR) ? !bit_val : bit_val;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Phase 0 decodes, 1 reads, 2 processes, 3 writes
    // Free-running: every instruction cycle is exactly four clocks
    always_comb begin
        phase_next = phase_reg + 2'h1;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            phase_reg <= PHASE_RESET;
        end else begin
            phase_reg <= phase_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // The fields are latched so the operation stays put even if the fetch
    // word changes mid-cycle
    always_comb begin
        kind_next = kind_reg;
        bit_next = bit_reg;
        off_next = off_reg;
        addr_next = addr_reg;
        acc_next = acc_reg;
        if (phase_reg == 2'h0) begin
            if (idle_reg || !instr_valid) begin
                // A word offered in an idle cycle is dropped without any indication
                kind_next = OP_NONE;
            end else begin
                kind_next = dec.kind;
                bit_next = dec.bit_idx;
                off_next = dec.rel_offset;
                // Bank and indexed addressing are left to the register file side
                addr_next = dec.file_addr;
                acc_next = dec.access_sel;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            kind_reg <= OP_NONE;
            bit_reg <= 3'h0;
            off_reg <= '0;
            addr_reg <= 8'h00;
            acc_reg <= 1'b0;
        end else begin
            kind_reg <= kind_next;
            bit_reg <= bit_next;
            off_reg <= off_next;
            addr_reg <= addr_next;
            acc_reg <= acc_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data is captured once and then modified in place, so the write
    // back needs no second read port
    always_comb begin
        wdata_next = wdata_reg;
        wen_next = 1'b0;
        case (phase_reg)
            2'h1: begin
                wdata_next = file_rd_data;
            end
            2'h2: begin
                if (kind_reg == OP_SET_BIT) begin
                    wdata_next = wdata_reg | (8'h01 << bit_reg);
                end
            end
            2'h3: begin
                // The strobe stands during phase 0 of the next cycle only
                wen_next = (kind_reg == OP_SET_BIT);
            end
            default: begin
                wen_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wdata_reg <= 8'h00;
            wen_reg <= 1'b0;
        end else begin
            wdata_reg <= wdata_next;
            wen_reg <= wen_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Program counter and idle-cycle control, all settled at the phase 3 edge
    // Offsets arrive already doubled and sign-extended from the decoder
    always_comb begin
        pc_next = pc_reg;
        idle_next = idle_reg;
        hold_next = hold_reg;
        taken_next = 1'b0;
        if (phase_reg == 2'h3) begin
            // Tells the fetch side that the word was consumed
            taken_next = !idle_reg && instr_valid;
            pc_next = pc_reg + PC_STEP;
            idle_next = 1'b0;
            hold_next = 1'b0;
            case (kind_reg)
                OP_JUMP: begin
                    pc_next = branch_target(pc_reg, off_reg);
                    idle_next = 1'b1;
                    hold_next = 1'b1;
                end
                OP_COND_JUMP: begin
                    if (!zero_flag) begin
                        pc_next = branch_target(pc_reg, off_reg);
                        idle_next = 1'b1;
                        hold_next = 1'b1;
                    end
                end
                OP_SKIP_CLEAR, OP_SKIP_SET: begin
                    // Skipping a two-word instruction is not handled: every word is one
                    idle_next = skip_hit(kind_reg, wdata_reg, bit_reg);
                end
                default: begin
                    idle_next = 1'b0;
                end
            endcase
            // A branch already points at its target, so its idle cycle holds the
            // counter; the idle cycle of a skip steps over the dropped word.
            if (idle_reg && hold_reg) begin
                pc_next = pc_reg;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pc_reg <= PC_RESET;
            idle_reg <= 1'b0;
            hold_reg <= 1'b0;
            taken_reg <= 1'b0;
        end else begin
            pc_reg <= pc_next;
            idle_reg <= idle_next;
            hold_reg <= hold_next;
            taken_reg <= taken_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign program_counter = pc_reg;
    assign file_addr = addr_reg;
    assign file_access_sel = acc_reg;
    assign file_wr_data = wdata_reg;
    assign file_wr_en = wen_reg;
    assign idle_cycle = idle_reg;
    assign phase = phase_reg;
    assign instr_taken = taken_reg;
endmodule

/* File: inc/branch_bit_pkg.sv */
// Package of opcode fields, widths and constants for the branch and bit-op decoder
package branch_bit_pkg;
    localparam int PC_WIDTH = 21;
    localparam int INSTR_WIDTH = 16;
    localparam int DATA_WIDTH = 8;
    localparam int FILE_ADDR_WIDTH = 8;
    localparam int BIT_IDX_WIDTH = 3;
    localparam int JUMP_OFFSET_WIDTH = 11;
    localparam int COND_OFFSET_WIDTH = 8;
    // Field positions inside the instruction word
    localparam int OPC_HI_POS = 12;
    localparam int BIT_IDX_POS = 9;
    localparam int ACCESS_SEL_POS = 8;
    localparam int JUMP_SEL_POS = 11;
    // Opcode patterns
    localparam logic [3:0] OPC_JUMP = 4'hd;
    localparam logic [7:0] OPC_COND_JUMP = 8'he1;
    localparam logic [3:0] OPC_SET_BIT = 4'h8;
    localparam logic [3:0] OPC_SKIP_CLEAR = 4'hb;
    localparam logic [3:0] OPC_SKIP_SET = 4'ha;
    // Branch base advance, in bytes, for a one-word instruction
    localparam logic [PC_WIDTH-1:0] PC_STEP = 21'h000002;
    localparam logic [PC_WIDTH-1:0] PC_RESET = 21'h000000;
    localparam int PHASE_COUNT = 4;
    localparam logic [1:0] PHASE_RESET = 2'h0;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_JUMP,
        OP_COND_JUMP,
        OP_SET_BIT,
        OP_SKIP_CLEAR,
        OP_SKIP_SET
    } op_kind_t;
endpackage

/* File: inc/decode_if.sv */
// Interface carrying the decoded instruction fields from decoder to executor
interface decode_if;
    import branch_bit_pkg::*;
    op_kind_t kind;
    logic [20:0] rel_offset;
    logic [2:0] bit_idx;
    logic access_sel;
    logic [7:0] file_addr;
    logic [15:0] instr;
    modport src (input instr, output kind, rel_offset, bit_idx, access_sel, file_addr);
    modport dst (output instr, input kind, rel_offset, bit_idx, access_sel, file_addr);
endinterface

/* File: rtl/instr_field_decoder.sv */
// Combinational opcode decoder for the branch and bit-op instructions
module instr_field_decoder
    import branch_bit_pkg::*;
(
    decode_if.src dec // Instruction in, decoded fields out
);
    // Sign-extend an offset field and double it
    function automatic logic [PC_WIDTH-1:0] scaled_offset(input logic [10:0] raw, input int bits);
        logic [PC_WIDTH-1:0] ext;
        ext = '0;
        for (int i = 0; i < PC_WIDTH; i++) begin
            ext[i] = raw[(i < bits) ? i : bits - 1];
        end
        return {ext[PC_WIDTH-2:0], 1'b0};
    endfunction

    always_comb begin
        dec.kind = OP_NONE;
        dec.rel_offset = '0;
        dec.bit_idx = dec.instr[BIT_IDX_POS +: BIT_IDX_WIDTH];
        dec.access_sel = dec.instr[ACCESS_SEL_POS];
        dec.file_addr = dec.instr[FILE_ADDR_WIDTH-1:0];
        if (dec.instr[15:OPC_HI_POS] == OPC_JUMP && !dec.instr[JUMP_SEL_POS]) begin
            dec.kind = OP_JUMP;
            dec.rel_offset = scaled_offset(dec.instr[10:0], JUMP_OFFSET_WIDTH);
        end else if (dec.instr[15:8] == OPC_COND_JUMP) begin
            dec.kind = OP_COND_JUMP;
            dec.rel_offset = scaled_offset({3'h0, dec.instr[7:0]}, COND_OFFSET_WIDTH);
        end else if (dec.instr[15:OPC_HI_POS] == OPC_SET_BIT) begin
            dec.kind = OP_SET_BIT;
        end else if (dec.instr[15:OPC_HI_POS] == OPC_SKIP_CLEAR) begin
            dec.kind = OP_SKIP_CLEAR;
        end else if (dec.instr[15:OPC_HI_POS] == OPC_SKIP_SET) begin
            dec.kind = OP_SKIP_SET;
        end
    end
endmodule

/* File: dv/relative_branch_bit_ops_sva.sv */
// Checker of branch and bit-op timing seen at the executor ports
module relative_branch_bit_ops_sva
    import branch_bit_pkg::*;
(
    input wire logic clock, // Clock
    input wire logic sys_rst, // Reset
    input wire logic [15:0] instr_word, // Word
    input wire logic instr_valid, // Valid
    input wire logic zero_flag, // Zero flag
    input wire logic [7:0] file_rd_data, // Read data
    input wire logic [20:0] program_counter, // Counter
    input wire logic [7:0] file_addr, // Address
    input wire logic file_access_sel, // Access bit
    input wire logic [7:0] file_wr_data, // Write data
    input wire logic file_wr_en, // Write strobe
    input wire logic idle_cycle, // Idle
    input wire logic [1:0] phase, // Phase
    input wire logic instr_taken // Consumed
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    wire logic is_jmp = instr_word[15:11] == 5'h1a;
    wire logic is_cj = instr_word[15:8] == 8'he1;
    wire logic is_set = instr_word[15:12] == 4'h8;
    wire logic is_skip = instr_word[15:13] == 3'h5;
    // Skip holds when the tested bit differs from the opcode's low bit
    wire logic skip_hit = instr_word[12] ^ file_rd_data[instr_word[11:9]];
    ////////////////////////////////////////
    sequence dec(hit);
        phase == 2'h0 && instr_valid && !idle_cycle && hit;
    endsequence
    sequence done(hit);
        dec(hit) ##3 1'b1;
    endsequence
    AST_PHASE_STEP: assert property (1'b1 |=> phase == 2'($past(phase) + 2'h1))
        else $error("Phase did not advance by one");
    AST_COUNTER_HOLD: assert property (phase != 2'h3 |=> $stable(program_counter))
        else $error("Program counter moved outside the last phase");
    AST_JUMP_TARGET: assert property (done(is_jmp) |=>
        program_counter == 21'($past(program_counter, 4) + 21'h2
        + {{9{$past(instr_word[10], 4)}}, $past(instr_word[10:0], 4), 1'b0}))
        else $error("Jump target wrong");
    AST_JUMP_IDLE: assert property (done(is_jmp) |=> idle_cycle [*4])
        else $error("Jump not followed by one idle cycle");
    AST_CJ_TAKEN: assert property (dec(is_cj) ##3 !zero_flag |=> idle_cycle &&
        program_counter == 21'($past(program_counter, 4) + 21'h2
        + {{12{$past(instr_word[7], 4)}}, $past(instr_word[7:0], 4), 1'b0}))
        else $error("Zero-clear jump not taken");
    AST_CJ_FALL: assert property (dec(is_cj) ##3 zero_flag |=> !idle_cycle &&
        program_counter == 21'($past(program_counter, 4) + 21'h2))
        else $error("Zero-clear jump did not fall through");
    AST_SET_BIT: assert property (dec(is_set) |-> ##4 file_wr_en && file_wr_data ==
        ($past(file_rd_data, 3) | (8'h01 << $past(instr_word[11:9], 4))) ##1 !file_wr_en)
        else $error("Bit set write back wrong");
    AST_SKIP_IDLE: assert property (dec(is_skip) ##1 skip_hit ##2 1'b1 |=> idle_cycle [*4])
        else $error("True skip not followed by idle cycle");
    AST_NO_SKIP: assert property (dec(is_skip) ##1 !skip_hit ##2 1'b1 |=> !idle_cycle)
        else $error("False skip produced idle cycle");
    AST_JUMP_HOLD: assert property (done(is_jmp) ##4 1'b1 |=>
        program_counter == $past(program_counter, 4))
        else $error("Counter moved during the idle cycle of a jump");
    AST_SKIP_STEP: assert property (dec(is_skip) ##1 skip_hit ##6 1'b1 |=>
        program_counter == 21'($past(program_counter, 8) + 21'h4))
        else $error("Skip did not step over the dropped word");
    AST_FILE_ADDR: assert property (dec(is_set || is_skip) |=>
        file_addr == $past(instr_word[7:0]) && file_access_sel == $past(instr_word[8]))
        else $error("Register address not taken from the word");
endmodule
bind relative_branch_bit_ops relative_branch_bit_ops_sva i_sva (.clock(clock), .sys_rst(sys_rst),
    .instr_word(instr_word), .instr_valid(instr_valid), .zero_flag(zero_flag),
    .file_rd_data(file_rd_data), .program_counter(program_counter), .file_addr(file_addr),
    .file_access_sel(file_access_sel), .file_wr_data(file_wr_data), .file_wr_en(file_wr_en),
    .idle_cycle(idle_cycle), .phase(phase), .instr_taken(instr_taken));

/* File: dv/relative_branch_bit_ops_test.sv */
// Self-checking bench for the relative branch and bit-op executor
module relative_branch_bit_ops_test
    import branch_bit_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic instr_valid = 1'b0;
    logic zero_flag = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic [7:0] file_rd_data = 8'h00;
    wire logic [20:0] program_counter;
    wire logic [7:0] file_addr;
    wire logic [7:0] file_wr_data;
    wire logic file_access_sel;
    wire logic file_wr_en;
    wire logic idle_cycle;
    wire logic instr_taken;
    wire logic [1:0] phase;
    int num_errors = 0;
    int n_compared = 0;
    logic [15:0] lfsr = 16'hcea5;
    logic [20:0] exp_prog = 21'h0;
    logic [20:0] idle_step = 21'h0;
    logic [7:0] exp_data = 8'h00;
    logic exp_idle = 1'b0;
    logic exp_wr = 1'b0;
    logic exp_take = 1'b0;
    relative_branch_bit_ops i_relative_branch_bit_ops (.clock(clock), .sys_rst(sys_rst),
        .instr_word(instr_word), .instr_valid(instr_valid), .zero_flag(zero_flag),
        .file_rd_data(file_rd_data), .program_counter(program_counter), .file_addr(file_addr),
        .file_access_sel(file_access_sel), .file_wr_data(file_wr_data), .file_wr_en(file_wr_en),
        .idle_cycle(idle_cycle), .phase(phase), .instr_taken(instr_taken));
    ////////////////////////////////////////
    function automatic logic [15:0] lfsr_next(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Idle after a jump holds the counter; idle after a skip steps over the dropped word
    function automatic void model(logic [15:0] w, logic zf, logic [7:0] rd);
        exp_take = !exp_idle;
        exp_wr = 1'b0;
        if (exp_idle) begin
            exp_prog = exp_prog + idle_step;
            exp_idle = 1'b0;
        end else begin
            exp_prog = exp_prog + 21'h2;
            idle_step = 21'h2;
            if (w[15:11] == 5'h1a || (w[15:8] == 8'he1 && !zf)) begin
                exp_prog = exp_prog + (w[15:11] == 5'h1a ? {{9{w[10]}}, w[10:0], 1'b0}
                    : {{12{w[7]}}, w[7:0], 1'b0});
                exp_idle = 1'b1;
                idle_step = 21'h0;
            end
            if (w[15:12] == 4'h8) begin
                exp_wr = 1'b1;
                exp_data = rd | (8'h01 << w[11:9]);
            end
            if (w[15:13] == 3'h5) exp_idle = w[12] ^ rd[w[11:9]];
        end
    endfunction
    task automatic check(string what, logic [31:0] got, logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic run_cycle(logic [15:0] w, logic zf, logic [7:0] rd);
        instr_word <= w;
        zero_flag <= zf;
        file_rd_data <= rd;
        instr_valid <= exp_idle ? lfsr[0] : 1'b1;
        @(negedge clock);
        check("counter", program_counter, exp_prog);
        check("phase", phase, 32'h0);
        check("idle", idle_cycle, exp_idle);
        check("wr_en", file_wr_en, exp_wr);
        check("taken", instr_taken, exp_take);
        if (exp_wr) check("wr_data", file_wr_data, exp_data);
        model(w, zf, rd);
        @(negedge clock);
        if (exp_take && (w[15:12] == 4'h8 || w[15:13] == 3'h5)) begin
            check("addr", {file_access_sel, file_addr}, w[8:0]);
        end
        repeat (3) @(posedge clock);
    endtask
    // An idle cycle drops the offered word, so a throwaway word fills it
    task automatic step(logic [15:0] w, logic zf, logic [7:0] rd);
        run_cycle(w, zf, rd);
        if (exp_idle) run_cycle(lfsr, !zf, ~rd);
    endtask
    task automatic final_report;
        $display("Compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        forever #2 clock = ~clock;
    end
    initial begin
        repeat (4000) @(posedge clock);
        num_errors++;
        final_report();
    end
    initial begin
        logic [15:0] w;
        repeat (10) @(posedge clock);
        sys_rst <= 1'b0;
        step(16'hd3ff, 1'b0, 8'h00);
        step(16'hd400, 1'b1, 8'h00);
        step(16'he180, 1'b0, 8'h00);
        step(16'he17f, 1'b1, 8'h00);
        step(16'h8e55, 1'b0, 8'h0a);
        step(16'hb4aa, 1'b0, 8'hfb);
        step(16'hb2aa, 1'b0, 8'hfb);
        step(16'ha5cc, 1'b1, 8'h04);
        step(16'ha5cc, 1'b1, 8'h00);
        $display("Test directed done");
        for (int i = 0; i < 300; i++) begin
            lfsr = lfsr_next(lfsr);
            w = lfsr;
            lfsr = lfsr_next(lfsr);
            case (i % 5)
                0: w = {5'h1a, w[10:0]};
                1: w = {8'he1, w[7:0]};
                2: w = {4'h8, w[11:0]};
                3: w = {4'hb, w[11:0]};
                default: w = {4'ha, w[11:0]};
            endcase
            step(w, lfsr[9], lfsr[7:0]);
        end
        $display("Test random done");
        final_report();
    end
endmodule
